// file: ghspc_pkg.sv
package ghspc_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam int unsigned PULSE_WIDTH_MS = 100;
  localparam int unsigned SECOND_MS = 1000;
  localparam int unsigned PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_WIDTH_MS;
  localparam int unsigned SECOND_CYCLES = (CLK_HZ / 1000) * SECOND_MS;
  localparam int unsigned PERIOD_ON_CYCLES = SECOND_CYCLES;
  localparam int unsigned PERIOD_OFF_CYCLES = 4 * SECOND_CYCLES;
  localparam logic [7:0] CMD_STANDBY = 8'h53;
  localparam logic [7:0] CMD_PERIODIC = 8'h50;
  localparam logic [7:0] CMD_ADAPTIVE = 8'h41;
  localparam logic [7:0] CMD_NORMAL = 8'h4E;
  localparam logic [7:0] CMD_BAUD_115K = 8'h42;
  localparam logic [15:0] BAUD_DIV_FAST = 16'(CLK_HZ / 115200);
  localparam logic [7:0] SENT_GGA = 8'h01;
  localparam logic [7:0] SENT_GSA = 8'h02;
  localparam logic [7:0] SENT_GSV = 8'h04;
  localparam logic [7:0] SENT_RMC = 8'h08;
  localparam logic [7:0] SENT_DEFAULT = 8'h0F;
  localparam int unsigned LOG_DEPTH = 16;

  typedef enum logic [1:0] {
    GHSPC_START_COLD,
    GHSPC_START_WARM,
    GHSPC_START_HOT
  } ghspc_start_type;

  typedef struct packed {
    logic [31:0] utc;
    logic [31:0] latitude;
    logic [31:0] longitude;
    logic valid;
    logic [7:0] checksum;
  } ghspc_log_entry_type;

endpackage

// file: ghspc_uart_rx.sv
`timescale 1ns/1ps
module ghspc_uart_rx
  import ghspc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] baud_div_i,
  input wire logic serial_in_i,
  output logic [7:0] data_o,
  output logic valid_o,
  output logic frame_err_o
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ghspc_rx_st_type;

  ghspc_rx_st_type st_reg;
  logic [15:0] cnt_reg;
  logic [3:0] idx_reg;
  logic [7:0] shift_reg;
  logic [15:0] half_div;

  assign half_div = {1'b0, baud_div_i[15:1]};

  // Mid-bit sampling; start rechecked at half period to reject glitches
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= RX_IDLE;
      cnt_reg <= 16'h0000;
      idx_reg <= 4'h0;
      shift_reg <= 8'h00;
      data_o <= 8'h00;
      valid_o <= 1'b0;
      frame_err_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      frame_err_o <= 1'b0;
      case (st_reg)
        RX_IDLE: begin
          cnt_reg <= 16'h0000;
          if (!serial_in_i) begin
            st_reg <= RX_START;
          end
        end
        RX_START: begin
          if (cnt_reg == half_div) begin
            cnt_reg <= 16'h0000;
            idx_reg <= 4'h0;
            st_reg <= serial_in_i ? RX_IDLE : RX_DATA;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        RX_DATA: begin
          if (cnt_reg == baud_div_i - 16'h0001) begin
            cnt_reg <= 16'h0000;
            shift_reg <= {serial_in_i, shift_reg[7:1]};
            if (idx_reg == LAST_DATA_IDX) begin
              st_reg <= RX_STOP;
            end else begin
              idx_reg <= idx_reg + 4'h1;
            end
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        RX_STOP: begin
          if (cnt_reg == baud_div_i - 16'h0001) begin
            st_reg <= RX_IDLE;
            if (serial_in_i) begin
              data_o <= shift_reg;
              valid_o <= 1'b1;
            end else begin
              frame_err_o <= 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: st_reg <= RX_IDLE;
      endcase
    end
  end

endmodule // ghspc_uart_rx

// file: ghspc_top.sv
`timescale 1ns/1ps
module ghspc_top
  import ghspc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic retention_supply_i,
  input wire logic long_outage_i,
  input wire logic moving_i,
  input wire logic serial_in_primary_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic fix_valid_i,
  input wire logic [31:0] fix_utc_i,
  input wire logic [31:0] fix_lat_i,
  input wire logic [31:0] fix_lon_i,
  output logic serial_out_primary_o,
  output logic tx_ready_o,
  output logic second_time_pulse_o,
  output logic standby_o,
  output logic [1:0] start_kind_o,
  output logic [7:0] sentence_mask_o,
  output logic [7:0] tx_checksum_o,
  output logic [3:0] log_count_o
);

  // ---------------------------------------------------------------
  // Reset
  // ---------------------------------------------------------------
  logic rst_n;
  logic sup_low_a_reg;
  logic sup_low_b_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_low_a_reg <= 1'b0;
      sup_low_b_reg <= 1'b0;
    end else begin
      sup_low_a_reg <= supply_low_i;
      sup_low_b_reg <= sup_low_a_reg;
    end
  end

  // Pin reset and brown-out combine; the pin is never an output
  assign rst_n = rst_n_i & ~sup_low_b_reg;

  // ---------------------------------------------------------------
  // Start kind, caught after reset release
  // ---------------------------------------------------------------
  logic start_seen_reg;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_seen_reg <= 1'b0;
      start_kind_o <= GHSPC_START_COLD;
    end else if (!start_seen_reg) begin
      start_seen_reg <= 1'b1;
      if (!retention_supply_i) begin
        start_kind_o <= GHSPC_START_COLD;
      end else if (long_outage_i) begin
        start_kind_o <= GHSPC_START_WARM;
      end else begin
        start_kind_o <= GHSPC_START_HOT;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial receiver
  // ---------------------------------------------------------------
  logic [15:0] baud_div_reg;
  logic [7:0] rx_data;
  logic rx_valid;

  ghspc_uart_rx u_rx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .baud_div_i(baud_div_reg),
    .serial_in_i(serial_in_primary_i),
    .data_o(rx_data),
    .valid_o(rx_valid),
    .frame_err_o()
  );

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic wake_hit;
  logic cmd_standby;
  logic cmd_periodic;
  logic cmd_adaptive;
  logic cmd_normal;
  logic cmd_fast;

  // A waking byte is consumed, so no command fires from standby
  always_comb begin
    wake_hit = rx_valid && standby_o;
    cmd_standby = rx_valid && !standby_o && (rx_data == CMD_STANDBY);
    cmd_periodic = rx_valid && !standby_o && (rx_data == CMD_PERIODIC);
    cmd_adaptive = rx_valid && !standby_o && (rx_data == CMD_ADAPTIVE);
    cmd_normal = rx_valid && !standby_o && (rx_data == CMD_NORMAL);
    cmd_fast = rx_valid && !standby_o && (rx_data == CMD_BAUD_115K);
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      baud_div_reg <= BAUD_DIV_RESET;
    end else if (cmd_fast) begin
      baud_div_reg <= BAUD_DIV_FAST;
    end
  end

  // ---------------------------------------------------------------
  // Sentence selection
  // ---------------------------------------------------------------
  // Fixed default set; no command alters it here
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sentence_mask_o <= SENT_DEFAULT;
    end else begin
      sentence_mask_o <= SENT_GGA | SENT_GSA | SENT_GSV | SENT_RMC;
    end
  end

  // ---------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PM_NORMAL, PM_STANDBY, PM_PERIODIC, PM_ADAPTIVE} ghspc_pm_type;

  ghspc_pm_type pm_reg;
  logic [31:0] phase_cnt_reg;
  logic [31:0] phase_len;

  // Adaptive: shorter sleep while moving, longer when still
  always_comb begin
    if (standby_o) begin
      phase_len = (pm_reg == PM_ADAPTIVE && !moving_i) ?
                  32'(2 * PERIOD_OFF_CYCLES) : 32'(PERIOD_OFF_CYCLES);
    end else begin
      phase_len = (pm_reg == PM_ADAPTIVE && moving_i) ?
                  32'(2 * PERIOD_ON_CYCLES) : 32'(PERIOD_ON_CYCLES);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pm_reg <= PM_NORMAL;
      standby_o <= 1'b0;
      phase_cnt_reg <= 32'h0000_0000;
    end else if (wake_hit) begin
      // Any byte wakes and is consumed; a cycling mode falls to normal
      pm_reg <= PM_NORMAL;
      standby_o <= 1'b0;
      phase_cnt_reg <= 32'h0000_0000;
    end else if (cmd_standby) begin
      pm_reg <= PM_STANDBY;
      standby_o <= 1'b1;
    end else if (cmd_periodic) begin
      pm_reg <= PM_PERIODIC;
      phase_cnt_reg <= 32'h0000_0000;
    end else if (cmd_adaptive) begin
      pm_reg <= PM_ADAPTIVE;
      phase_cnt_reg <= 32'h0000_0000;
    end else if (cmd_normal) begin
      pm_reg <= PM_NORMAL;
      standby_o <= 1'b0;
    end else if (pm_reg == PM_PERIODIC || pm_reg == PM_ADAPTIVE) begin
      if (phase_cnt_reg >= phase_len - 32'h0000_0001) begin
        phase_cnt_reg <= 32'h0000_0000;
        standby_o <= ~standby_o;
      end else begin
        phase_cnt_reg <= phase_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Time pulse
  // ---------------------------------------------------------------
  logic [31:0] sec_cnt_reg;
  logic second_tick;

  assign second_tick = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_reg <= 32'h0000_0000;
      second_time_pulse_o <= 1'b0;
    end else begin
      sec_cnt_reg <= second_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      if (second_tick) begin
        second_time_pulse_o <= 1'b1;
      end else if (sec_cnt_reg == 32'(PULSE_CYCLES - 1)) begin
        second_time_pulse_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmitter with running record checksum
  // ---------------------------------------------------------------
  logic [15:0] tx_cnt_reg;
  logic [9:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;
  logic tx_busy;

  assign tx_busy = (tx_bits_reg != 4'h0);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_primary_o <= 1'b1;
      tx_ready_o <= 1'b0;
      tx_shift_reg <= 10'h3FF;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
    end else begin
      tx_ready_o <= !tx_busy && !tx_valid_i && !standby_o;
      if (!tx_busy) begin
        serial_out_primary_o <= 1'b1;
        if (tx_valid_i && tx_ready_o) begin
          tx_shift_reg <= {1'b1, tx_data_i, 1'b0};
          // Extra idle slot so the stop bit lasts a full bit time
          tx_bits_reg <= 4'hB;
          tx_cnt_reg <= 16'h0000;
        end
      end else if (tx_cnt_reg == 16'h0000) begin
        // Sends independently of receiver activity
        serial_out_primary_o <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_cnt_reg <= baud_div_reg - 16'h0001;
        tx_bits_reg <= tx_bits_reg - 4'h1;
      end else begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      end
    end
  end

  // XOR of bytes after the last '$'; '*' is skipped, bytes after it still XOR in
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_checksum_o <= 8'h00;
    end else if (tx_valid_i && tx_ready_o) begin
      if (tx_data_i == 8'h24) begin
        tx_checksum_o <= 8'h00;
      end else if (tx_data_i != 8'h2A) begin
        tx_checksum_o <= tx_checksum_o ^ tx_data_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Logger
  // ---------------------------------------------------------------
  ghspc_log_entry_type log_mem [LOG_DEPTH];
  ghspc_log_entry_type log_next;
  logic [3:0] log_wr_reg;

  always_comb begin
    log_next.utc = fix_utc_i;
    log_next.latitude = fix_lat_i;
    log_next.longitude = fix_lon_i;
    log_next.valid = fix_valid_i;
    log_next.checksum = fix_utc_i[7:0] ^ fix_lat_i[7:0] ^ fix_lon_i[7:0] ^ {7'h00, fix_valid_i};
  end

  // Ring buffer, overwrites oldest; no host or external memory
  always_ff @(posedge core_clk_i) begin
    if (second_tick && !standby_o) begin
      log_mem[log_wr_reg] <= log_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      log_wr_reg <= 4'h0;
      log_count_o <= 4'h0;
    end else if (second_tick && !standby_o) begin
      log_wr_reg <= log_wr_reg + 4'h1;
      if (log_count_o != 4'hF) begin
        log_count_o <= log_count_o + 4'h1;
      end
    end
  end

endmodule // ghspc_top

// file: ghspc_top_chk.sv
`timescale 1ns/1ps
module ghspc_top_chk
  import ghspc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic retention_supply_i,
  input wire logic long_outage_i,
  input wire logic serial_in_primary_i,
  input wire logic tx_valid_i,
  input wire logic serial_out_primary_o,
  input wire logic tx_ready_o,
  input wire logic second_time_pulse_o,
  input wire logic standby_o,
  input wire logic [1:0] start_kind_o,
  input wire logic [7:0] sentence_mask_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------
  // Run counters
  // ----------------
  // Counters stand in for repetitions far beyond what the tools unroll
  logic [31:0] low_reg;
  logic [31:0] busy_reg;
  logic [31:0] wake_reg;
  logic [31:0] high_reg;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_reg <= '0;
      busy_reg <= '1;
      wake_reg <= '0;
      high_reg <= '0;
    end else begin
      low_reg <= serial_out_primary_o ? '0 : low_reg + 1;
      busy_reg <= (tx_valid_i && tx_ready_o) ? '0 : busy_reg + 32'(busy_reg != '1);
      wake_reg <= (standby_o && (wake_reg != 0 || !serial_in_primary_i)) ? wake_reg + 1 : '0;
      high_reg <= second_time_pulse_o ? high_reg + 1 : '0;
    end
  end
  // ----------------
  // Checks
  // ----------------
  stop_run_a: assert property ($rose(serial_out_primary_o) |-> low_reg >= BAUD_DIV_FAST)
    else $error("serial low run shorter than a bit");
  take_start_a: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o ##1 !serial_out_primary_o)
    else $error("no start bit after take");
  frame_busy_a: assert property ($rose(tx_ready_o) |-> busy_reg >= 10 * BAUD_DIV_FAST - 1)
    else $error("ready back before frame end");
  stby_quiet_a: assert property (standby_o && $past(standby_o) |-> !tx_ready_o)
    else $error("ready while in standby");
  wake_bound_a: assert property (wake_reg < 11 * BAUD_DIV_FAST)
    else $error("no wake after received byte");
  mask_fixed_a: assert property (sentence_mask_o == SENT_DEFAULT)
    else $error("sentence mask not default");
  supply_rst_a: assert property (supply_low_i [*4] |-> serial_out_primary_o && !standby_o && !tx_ready_o)
    else $error("low supply did not reset");
  start_kind_a: assert property ($rose(rst_n_i) |=> start_kind_o == (!$past(retention_supply_i) ? GHSPC_START_COLD : $past(long_outage_i) ? GHSPC_START_WARM : GHSPC_START_HOT))
    else $error("wrong start kind");
  pulse_width_a: assert property ($fell(second_time_pulse_o) |-> high_reg == PULSE_CYCLES)
    else $error("time pulse width wrong");
  cover property ($rose(standby_o));
  cover property ($fell(standby_o));
  cover property (tx_valid_i && tx_ready_o);
  cover property (supply_low_i [*4]);
endmodule // ghspc_top_chk

bind ghspc_top ghspc_top_chk chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .supply_low_i(supply_low_i), .retention_supply_i(retention_supply_i),
  .long_outage_i(long_outage_i), .serial_in_primary_i(serial_in_primary_i),
  .tx_valid_i(tx_valid_i), .serial_out_primary_o(serial_out_primary_o),
  .tx_ready_o(tx_ready_o), .second_time_pulse_o(second_time_pulse_o),
  .standby_o(standby_o), .start_kind_o(start_kind_o), .sentence_mask_o(sentence_mask_o));

// file: ghspc_host_model.sv
`timescale 1ns/1ps
module ghspc_host_model (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int div = 5208;
  int n_frame_err = 0;
  logic [7:0] rx_q[$];
  // Host end is pulled up, so the line rests high between frames
  initial line_o = 1'b1;
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      line_o = f[i];
      repeat (div - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    line_o = 1'b1;
    // A dropped frame needs idle line before the next start edge
    if (!stop) repeat (div) @(negedge clk_i);
  endtask
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line_i);
      repeat (div / 2) @(posedge clk_i);
      if (line_i === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (div) @(posedge clk_i);
          b[i] = line_i;
        end
        repeat (div) @(posedge clk_i);
        if (line_i !== 1'b1) n_frame_err++;
        rx_q.push_back(b);
      end
    end
  end
endmodule // ghspc_host_model

// file: ghspc_top_test.sv
`timescale 1ns/1ps
module ghspc_top_test
  import ghspc_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_n_i, supply_low_i, retention_supply_i, long_outage_i, moving_i, serial_in_primary_i;
  logic tx_valid_i, fix_valid_i, serial_out_primary_o, tx_ready_o, second_time_pulse_o, standby_o;
  logic [7:0] tx_data_i, sentence_mask_o, tx_checksum_o;
  logic [31:0] fix_utc_i, fix_lat_i, fix_lon_i;
  logic [1:0] start_kind_o;
  logic [3:0] log_count_o;
  logic [15:0] lfsr_reg = 16'h5F4A;
  logic [7:0] cmds[3] = '{CMD_PERIODIC, CMD_ADAPTIVE, CMD_NORMAL};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  ghspc_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low_i),
    .retention_supply_i(retention_supply_i), .long_outage_i(long_outage_i), .moving_i(moving_i),
    .serial_in_primary_i(serial_in_primary_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .fix_valid_i(fix_valid_i), .fix_utc_i(fix_utc_i), .fix_lat_i(fix_lat_i),
    .fix_lon_i(fix_lon_i), .serial_out_primary_o(serial_out_primary_o), .tx_ready_o(tx_ready_o),
    .second_time_pulse_o(second_time_pulse_o), .standby_o(standby_o),
    .start_kind_o(start_kind_o), .sentence_mask_o(sentence_mask_o),
    .tx_checksum_o(tx_checksum_o), .log_count_o(log_count_o));
  ghspc_host_model host (.clk_i(core_clk_i), .line_i(serial_out_primary_o),
    .line_o(serial_in_primary_i));
  always #10 core_clk_i = ~core_clk_i;
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [7:0] rnd8();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg[7:0];
  endfunction
  function automatic logic [7:0] ck_next(input logic [7:0] c, input logic [7:0] d);
    if (d == 8'h24) return 8'h00;
    return (d == 8'h2A) ? c : c ^ d;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tx_byte(input logic [7:0] b);
    int n;
    n = host.rx_q.size();
    for (int i = 0; i < 100 && tx_ready_o !== 1'b1; i++) @(negedge core_clk_i);
    tx_data_i = b;
    tx_valid_i = 1'b1;
    @(negedge core_clk_i);
    tx_valid_i = 1'b0;
    for (int i = 0; i < 60000 && host.rx_q.size() == n; i++) @(negedge core_clk_i);
    chk(host.rx_q[n], b);
  endtask
  // Run length is bounded by the slow first frame
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    logic [7:0] ck, b;
    rst_n_i = 1'b0;
    supply_low_i = 1'b0;
    moving_i = 1'b0;
    tx_data_i = 8'h00;
    tx_valid_i = 1'b0;
    fix_valid_i = 1'b1;
    fix_utc_i = {rnd8(), rnd8(), rnd8(), rnd8()};
    fix_lat_i = {rnd8(), rnd8(), rnd8(), rnd8()};
    fix_lon_i = {rnd8(), rnd8(), rnd8(), rnd8()};
    retention_supply_i = 1'b0;
    long_outage_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    for (int k = 0; k < 3; k++) begin
      retention_supply_i = (k != 0);
      long_outage_i = (k == 1);
      rst_n_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      @(negedge core_clk_i);
      chk(tx_ready_o, 32'h1);
      @(negedge core_clk_i);
      chk(start_kind_o, k == 0 ? 32'h0 : k == 1 ? 32'h1 : 32'h2);
      chk(sentence_mask_o, SENT_DEFAULT);
      chk(second_time_pulse_o, 32'h0);
      chk(log_count_o, 32'h0);
    end
    fork
      tx_byte(8'h24);
      begin
        repeat (BAUD_DIV_RESET) @(negedge core_clk_i);
        host.send_byte(CMD_BAUD_115K, 1'b1);
      end
    join
    ck = 8'h00;
    chk(tx_checksum_o, ck);
    host.div = int'(BAUD_DIV_FAST);
    host.send_byte(CMD_STANDBY, 1'b0);
    chk(standby_o, 32'h0);
    host.send_byte(CMD_STANDBY, 1'b1);
    chk(standby_o, 32'h1);
    chk(tx_ready_o, 32'h0);
    host.send_byte(rnd8(), 1'b1);
    chk(standby_o, 32'h0);
    for (int m = 0; m < 3; m++) begin
      b = (m == 2) ? 8'h2A : rnd8();
      moving_i = b[0];
      fork
        tx_byte(b);
        host.send_byte(cmds[m], 1'b1);
      join
      ck = ck_next(ck, b);
      chk(tx_checksum_o, ck);
      chk(standby_o, 32'h0);
    end
    host.send_byte(CMD_STANDBY, 1'b1);
    chk(standby_o, 32'h1);
    supply_low_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk(standby_o, 32'h0);
    chk(serial_out_primary_o, 32'h1);
    supply_low_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    chk(start_kind_o, 32'h2);
    chk(host.n_frame_err, 32'h0);
    conclude();
  end
endmodule // ghspc_top_test
